// ===== core/bank_tracker.sv
/*
 * One bank's state tracker with its own timer.
 * Assumes the parent decides legality and only presents accepted commands.
 */
`timescale 1ns/1ps
module bank_tracker
    import bank_legal_pkg::*;
(
    // clock and reset
    input wire logic clk_in,
    input wire logic reset_in,
    // accepted command aimed at this bank
    input wire logic hit_in,
    input wire command_type cmd_in,
    input wire logic bst_hit_in,
    // forced return to idle after device-wide operations
    input wire logic force_idle_in,
    // state
    output bank_state_type state_out,
    output logic burst_out
);

    typedef struct packed {
        bank_state_type state;
        logic [CNT_BITS-1:0] timer;
    } bank_reg_type;

    bank_reg_type r;
    bank_reg_type next_r;

    always_comb begin
        next_r = r;
        if (r.timer != CNT_ZERO) begin
            next_r.timer = r.timer - CNT_ONE;
        end
        if (force_idle_in) begin
            next_r.state = BANK_IDLE;
            next_r.timer = CNT_ZERO;
        end else if (bst_hit_in) begin
            next_r.state = BANK_ACTIVE;
            next_r.timer = CNT_ZERO;
        end else if (hit_in) begin
            unique case (cmd_in.code)
                CMD_ACTIVATE: begin
                    next_r.state = BANK_ACTIVATING;
                    next_r.timer = CNT_BITS'(RCD_CYC);
                end
                CMD_READ: begin
                    next_r.state = cmd_in.auto_pre ? BANK_READING_AP : BANK_READING;
                    next_r.timer = cmd_in.burst_cycles;
                end
                CMD_WRITE: begin
                    next_r.state = cmd_in.auto_pre ? BANK_WRITING_AP : BANK_WRITING;
                    next_r.timer = cmd_in.burst_cycles;
                end
                CMD_PRECHARGE: begin
                    next_r.state = BANK_PRECHARGING;
                    next_r.timer = CNT_BITS'(RP_CYC);
                end
                CMD_MRR: begin
                    next_r.state = (r.state == BANK_ACTIVE) ? BANK_ACTIVE_MRR : BANK_IDLE_MRR;
                    next_r.timer = CNT_BITS'(MRR_CYC);
                end
                default: begin
                    next_r.state = r.state;
                end
            endcase
        end else if (r.timer == CNT_ZERO || r.timer == CNT_ONE) begin
            unique case (r.state)
                BANK_ACTIVATING: next_r.state = BANK_ACTIVE;
                BANK_PRECHARGING: next_r.state = BANK_IDLE;
                BANK_READING, BANK_WRITING: next_r.state = BANK_ACTIVE;
                BANK_READING_AP, BANK_WRITING_AP: begin
                    // auto precharge starts once the burst is out
                    next_r.state = BANK_PRECHARGING;
                    next_r.timer = CNT_BITS'(RP_CYC);
                end
                BANK_IDLE_MRR: next_r.state = BANK_IDLE;
                BANK_ACTIVE_MRR: next_r.state = BANK_ACTIVE;
                default: next_r.state = r.state;
            endcase
        end
    end

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            r <= '{state: BANK_IDLE, timer: CNT_ZERO};
        end else begin
            r <= next_r;
        end
    end

    assign state_out = r.state;
    assign burst_out = (r.state == BANK_READING) || (r.state == BANK_WRITING)
        || (r.state == BANK_READING_AP) || (r.state == BANK_WRITING_AP);

endmodule // bank_tracker

// ===== core/cross_bank_legality.sv
/*
 * Command legality and bank state logic for an eight-bank low-power DRAM.
 * Takes one command per clock, decides whether it is legal for the target
 * bank given every other bank, accepts or rejects it, and tracks states.
 * Assumes commands arrive synchronous to clk_in; clock enable is a pin.
 */
`timescale 1ns/1ps
// Overview of operation
// - commands count only when clock enable is high now and last edge, after exit time
// - idle after precharge time, active after activate-to-access time
// - reading or writing lasts until the burst ends or is terminated
// - with another bank idle, any command legal for target is accepted; NOP continues
// - read or write moves target to reading or writing, with or without auto precharge
// - register read accepted while target is idle, activating, precharging or active
// - register read enters idle or active register-read by the target's own state
// - burst terminate ends the burst and returns that bank to active
// - register read from idle returns the bank to idle; from resetting it ends with all banks idle
// - register read from active returns the bank to active
// - register write holds the device until its time, then all banks idle
// - reset from power-on starts initialization; not bank-specific, all banks idle
// - register read while resetting enters resetting register read
module cross_bank_legality
    import bank_legal_pkg::*;
#(
    parameter int NUM_BANK = NUM_BANKS,
    parameter int INIT_CYCLES = INIT_CYC
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic reset_in,
    // pins
    input wire logic cke_in,
    input wire logic power_exit_in,
    // command from the controller
    input wire logic cmd_valid_in,
    input wire command_type cmd_in,
    // outcome
    output verdict_type verdict_out,
    output bank_state_type [NUM_BANK-1:0] bank_state_out,
    output dev_phase_type phase_out,
    output logic all_idle_out
);

    // refuse parameter values the logic cannot serve, at elaboration
    if (NUM_BANK != NUM_BANKS) begin : g_bad_banks
        $error("bank count must match bank address width");
    end
    if (INIT_CYCLES < 1 || INIT_CYCLES > 65535) begin : g_bad_init
        $error("init cycles out of range");
    end

    // ******************************************************************
    // state
    // ******************************************************************
    typedef struct packed {
        logic cke_meta;
        logic cke_sync;
        logic cke_prev;
        logic exit_meta;
        logic exit_sync;
        logic [CNT_BITS-1:0] exit_timer;
        dev_phase_type phase;
        logic [15:0] phase_timer;
        logic [CNT_BITS-1:0] rrd_timer;
        logic [BANK_BITS-1:0] last_burst_bank;
        verdict_type verdict;
    } top_reg_type;

    top_reg_type r;
    top_reg_type next_r;

    bank_state_type [NUM_BANK-1:0] bank_state;
    logic [NUM_BANK-1:0] bank_burst;
    logic [NUM_BANK-1:0] bank_hit;
    logic [NUM_BANK-1:0] bank_bst;
    logic force_idle;
    logic accept;
    logic legal;
    logic cmd_live;
    logic all_idle;
    logic any_read;
    logic any_write;
    logic any_burst;
    logic any_mrr;
    logic all_prechargeable;
    bank_state_type tgt;

    // ******************************************************************
    // per-bank trackers
    // ******************************************************************
    generate
        for (genvar b = 0; b < NUM_BANK; b++) begin : g_bank
            assign bank_hit[b] = accept && (cmd_in.code != CMD_BST)
                && ((cmd_in.bank == BANK_BITS'(b))
                || (cmd_in.code == CMD_PRECHARGE && cmd_in.all_banks));
            assign bank_bst[b] = accept && (cmd_in.code == CMD_BST)
                && (cmd_in.bank == BANK_BITS'(b));
            bank_tracker u_bank (
                .clk_in(clk_in),
                .reset_in(reset_in),
                .hit_in(bank_hit[b]),
                .cmd_in(cmd_in),
                .bst_hit_in(bank_bst[b]),
                .force_idle_in(force_idle),
                .state_out(bank_state[b]),
                .burst_out(bank_burst[b])
            );
        end
    endgenerate

    // ******************************************************************
    // summaries over all banks
    // ******************************************************************
    always_comb begin
        all_idle = 1'b1;
        any_read = 1'b0;
        any_write = 1'b0;
        any_mrr = 1'b0;
        all_prechargeable = 1'b1;
        for (int b = 0; b < NUM_BANK; b++) begin
            all_idle &= (bank_state[b] == BANK_IDLE);
            any_read |= (bank_state[b] == BANK_READING) || (bank_state[b] == BANK_READING_AP);
            any_write |= (bank_state[b] == BANK_WRITING) || (bank_state[b] == BANK_WRITING_AP);
            any_mrr |= (bank_state[b] == BANK_IDLE_MRR) || (bank_state[b] == BANK_ACTIVE_MRR);
            all_prechargeable &= (bank_state[b] == BANK_IDLE) || (bank_state[b] == BANK_ACTIVE)
                || (bank_state[b] == BANK_PRECHARGING) || (bank_state[b] == BANK_ACTIVATING);
        end
        any_burst = any_read || any_write;
    end

    assign tgt = bank_state[cmd_in.bank];
    // synced exit pin blocks at once; the exit timer is only loaded one edge later
    assign cmd_live = cmd_valid_in && r.cke_sync && r.cke_prev && !r.exit_sync
        && (r.exit_timer == CNT_ZERO) && (cmd_in.code != CMD_NOP);

    // ******************************************************************
    // legality
    // ******************************************************************
    always_comb begin
        legal = 1'b0;
        unique case (r.phase)
            DEV_POWER_ON: begin
                legal = (cmd_in.code == CMD_MRW_RESET);
            end
            DEV_RESETTING: begin
                legal = (cmd_in.code == CMD_MRR);
            end
            DEV_RESET_MRR, DEV_MRW: begin
                legal = 1'b0;
            end
            default: begin
                if (any_mrr) begin
                    legal = 1'b0;
                end else begin
                    unique case (cmd_in.code)
                        CMD_ACTIVATE: begin
                            legal = (tgt == BANK_IDLE) && (r.rrd_timer == CNT_ZERO);
                        end
                        CMD_READ: begin
                            legal = ((tgt == BANK_ACTIVE) || (tgt == BANK_READING)
                                || (tgt == BANK_WRITING)) && !(any_write && tgt != BANK_WRITING)
                                && cmd_in.burst_cycles != CNT_ZERO;
                        end
                        CMD_WRITE: begin
                            legal = ((tgt == BANK_ACTIVE) || (tgt == BANK_READING)
                                || (tgt == BANK_WRITING)) && !(any_read && tgt != BANK_READING)
                                && cmd_in.burst_cycles != CNT_ZERO;
                        end
                        CMD_PRECHARGE: begin
                            legal = cmd_in.all_banks ? all_prechargeable
                                : (tgt == BANK_IDLE || tgt == BANK_ACTIVE);
                        end
                        CMD_MRR: begin
                            legal = (tgt == BANK_IDLE) || (tgt == BANK_ACTIVATING)
                                || (tgt == BANK_PRECHARGING) || (tgt == BANK_ACTIVE);
                        end
                        CMD_BST: begin
                            legal = bank_burst[cmd_in.bank]
                                && (cmd_in.bank == r.last_burst_bank);
                        end
                        CMD_MRW, CMD_REFRESH, CMD_SELF_REFRESH: begin
                            legal = all_idle && !any_burst;
                        end
                        CMD_MRW_RESET: begin
                            legal = all_idle && !any_burst;
                        end
                        default: begin
                            legal = 1'b0;
                        end
                    endcase
                end
            end
        endcase
    end

    assign accept = cmd_live && legal && (r.phase == DEV_RUN);

    // ******************************************************************
    // device phase and timers
    // ******************************************************************
    always_comb begin
        next_r = r;
        force_idle = 1'b0;
        next_r.cke_meta = cke_in;
        next_r.cke_sync = r.cke_meta;
        next_r.cke_prev = r.cke_sync;
        next_r.exit_meta = power_exit_in;
        next_r.exit_sync = r.exit_meta;
        next_r.verdict = '{accepted: cmd_live && legal, rejected: cmd_live && !legal};
        if (r.exit_sync) begin
            next_r.exit_timer = CNT_BITS'(EXIT_CYC);
        end else if (r.exit_timer != CNT_ZERO) begin
            next_r.exit_timer = r.exit_timer - CNT_ONE;
        end
        if (r.rrd_timer != CNT_ZERO) begin
            next_r.rrd_timer = r.rrd_timer - CNT_ONE;
        end
        if (r.phase_timer != 16'h0000) begin
            next_r.phase_timer = r.phase_timer - 16'h0001;
        end
        if (accept && cmd_in.code == CMD_ACTIVATE) begin
            next_r.rrd_timer = CNT_BITS'(RRD_CYC - 1);
        end
        if (accept && (cmd_in.code == CMD_READ || cmd_in.code == CMD_WRITE)) begin
            next_r.last_burst_bank = cmd_in.bank;
        end
        unique case (r.phase)
            DEV_POWER_ON: begin
                if (cmd_live && legal) begin
                    next_r.phase = DEV_RESETTING;
                    next_r.phase_timer = 16'(INIT_CYCLES);
                end
            end
            DEV_RESETTING: begin
                if (cmd_live && legal) begin
                    next_r.phase = DEV_RESET_MRR;
                    next_r.phase_timer = 16'(MRR_CYC);
                end else if (r.phase_timer <= 16'h0001) begin
                    next_r.phase = DEV_RUN;
                end
            end
            DEV_RESET_MRR, DEV_MRW: begin
                if (r.phase_timer <= 16'h0001) begin
                    next_r.phase = DEV_RUN;
                    force_idle = 1'b1;
                end
            end
            default: begin
                if (accept && cmd_in.code == CMD_MRW) begin
                    next_r.phase = DEV_MRW;
                    next_r.phase_timer = 16'(MRW_CYC);
                end else if (accept && cmd_in.code == CMD_MRW_RESET) begin
                    next_r.phase = DEV_RESETTING;
                    next_r.phase_timer = 16'(INIT_CYCLES);
                end
            end
        endcase
    end

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            r <= '{phase: DEV_POWER_ON, default: '0};
        end else begin
            r <= next_r;
        end
    end

    assign verdict_out = r.verdict;
    assign bank_state_out = bank_state;
    assign phase_out = r.phase;
    assign all_idle_out = all_idle && (r.phase == DEV_RUN);

endmodule // cross_bank_legality

// ===== include/bank_legal_pkg.sv
/*
 * Shared types and constants for the multi-bank command legality tracker:
 * command codes, per-bank state encoding, device-wide phase and timing counts.
 * Assumes a 100 MHz command clock; timings are given in ns and converted here.
 */
package bank_legal_pkg;

    // ******************************************************************
    // sizes
    // ******************************************************************
    localparam int NUM_BANKS = 8;
    localparam int BANK_BITS = 3;
    localparam int CNT_BITS = 8;
    localparam int CLK_PERIOD_NS = 10;

    // ******************************************************************
    // timing figures (ns) and derived cycle counts, least times round up
    // ******************************************************************
    localparam int T_RCD_NS = 18;
    localparam int T_RP_NS = 18;
    localparam int T_MRR_NS = 20;
    localparam int T_MRW_NS = 50;
    localparam int T_RRD_NS = 10;
    localparam int T_EXIT_NS = 75;
    localparam int T_INIT_NS = 1000;

    function automatic int ns_to_cyc(input int ns);
        int c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction

    localparam int RCD_CYC = ns_to_cyc(T_RCD_NS);
    localparam int RP_CYC = ns_to_cyc(T_RP_NS);
    localparam int MRR_CYC = ns_to_cyc(T_MRR_NS);
    localparam int MRW_CYC = ns_to_cyc(T_MRW_NS);
    localparam int RRD_CYC = ns_to_cyc(T_RRD_NS);
    localparam int EXIT_CYC = ns_to_cyc(T_EXIT_NS);
    localparam int INIT_CYC = ns_to_cyc(T_INIT_NS);

    localparam logic [CNT_BITS-1:0] CNT_ZERO = 8'h00;
    localparam logic [CNT_BITS-1:0] CNT_ONE = 8'h01;

    // ******************************************************************
    // commands
    // ******************************************************************
    typedef enum logic [3:0] {
        CMD_NOP,
        CMD_ACTIVATE,
        CMD_READ,
        CMD_WRITE,
        CMD_PRECHARGE,
        CMD_MRR,
        CMD_MRW,
        CMD_MRW_RESET,
        CMD_BST,
        CMD_REFRESH,
        CMD_SELF_REFRESH
    } cmd_code_type;

    typedef struct packed {
        cmd_code_type code;
        logic [BANK_BITS-1:0] bank;
        logic all_banks;
        logic auto_pre;
        logic [CNT_BITS-1:0] burst_cycles;
    } command_type;

    // ******************************************************************
    // per-bank and device states
    // ******************************************************************
    typedef enum logic [3:0] {
        BANK_IDLE,
        BANK_ACTIVATING,
        BANK_ACTIVE,
        BANK_PRECHARGING,
        BANK_READING,
        BANK_WRITING,
        BANK_READING_AP,
        BANK_WRITING_AP,
        BANK_IDLE_MRR,
        BANK_ACTIVE_MRR
    } bank_state_type;

    typedef enum logic [2:0] {
        DEV_POWER_ON,
        DEV_RESETTING,
        DEV_RESET_MRR,
        DEV_MRW,
        DEV_RUN
    } dev_phase_type;

    typedef struct packed {
        logic accepted;
        logic rejected;
    } verdict_type;

endpackage

// ===== test/ctrl_model.sv
/* controller model: puts the bench's requests on the command bus.
   assumes requests change just after a clock edge. */
`timescale 1ns/1ps
module ctrl_model
    import bank_legal_pkg::*;
(
    // request from the bench
    input wire logic issue_in,
    input wire command_type req_in,
    // command bus
    output logic cmd_valid_out,
    output command_type cmd_out
);
    // *****
    // bus drive
    // *****
    assign cmd_valid_out = issue_in;
    // between commands only no-op, other fields scrambled so stale values never help
    assign cmd_out = issue_in ? req_in : {CMD_NOP, ~req_in[12:0]};
endmodule // ctrl_model

// ===== test/legality_asserts.sv
/* checker: port-level assertions for cross_bank_legality.
   assumes it is bound to every instance of that module. */
`timescale 1ns/1ps
module legality_checker
    import bank_legal_pkg::*;
#(
    parameter int NUM_BANK = NUM_BANKS
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic reset_in,
    // inputs
    input wire logic cke_in,
    input wire logic cmd_valid_in,
    input wire command_type cmd_in,
    // outputs
    input wire verdict_type verdict_out,
    input wire bank_state_type [NUM_BANK-1:0] bank_state_out,
    input wire dev_phase_type phase_out,
    input wire logic all_idle_out
);
    // *****
    // helpers
    // *****
    localparam int MRW_LIM = 8;
    logic any_wr;
    logic any_rd;
    logic real_cmd;
    always_comb begin
        any_wr = 1'b0;
        any_rd = 1'b0;
        for (int i = 0; i < NUM_BANK; i++) begin
            any_wr |= (bank_state_out[i] == BANK_WRITING);
            any_rd |= (bank_state_out[i] == BANK_READING);
        end
    end
    assign real_cmd = cmd_valid_in && cmd_in.code != CMD_NOP;
    default clocking @(posedge clk_in); endclocking
    default disable iff (reset_in);

    a_verdict_single: assert property (!(verdict_out.accepted && verdict_out.rejected))
        else $error("both verdicts at once");
    a_verdict_cause: assert property ((verdict_out.accepted || verdict_out.rejected)
        |-> $past(real_cmd)) else $error("verdict without command");
    a_cke_low_quiet: assert property (!cke_in [*4] |=> !verdict_out.accepted
        && !verdict_out.rejected) else $error("command taken with clock enable low");
    a_poweron_reset_only: assert property (phase_out == DEV_POWER_ON && real_cmd
        && cmd_in.code != CMD_MRW_RESET |=> !verdict_out.accepted) else $error("power-on accept");
    a_mode_lockout: assert property ((phase_out == DEV_MRW || phase_out == DEV_RESET_MRR)
        && real_cmd |=> !verdict_out.accepted) else $error("command taken in lockout");
    a_mrw_needs_idle: assert property (real_cmd && cmd_in.code == CMD_MRW && !all_idle_out
        |=> !verdict_out.accepted) else $error("register write with banks busy");
    a_act_state: assert property (real_cmd && cmd_in.code == CMD_ACTIVATE ##1
        verdict_out.accepted |-> bank_state_out[$past(cmd_in.bank)] == BANK_ACTIVATING)
        else $error("activate did not open bank");
    a_read_state: assert property (real_cmd && cmd_in.code == CMD_READ ##1 verdict_out.accepted
        |-> bank_state_out[$past(cmd_in.bank)] ==
        ($past(cmd_in.auto_pre) ? BANK_READING_AP : BANK_READING)) else $error("read state");
    a_bst_active: assert property (real_cmd && cmd_in.code == CMD_BST ##1 verdict_out.accepted
        |-> bank_state_out[$past(cmd_in.bank)] == BANK_ACTIVE) else $error("terminate state");
    a_cross_turnaround: assert property (real_cmd && ((cmd_in.code == CMD_READ && any_wr)
        || (cmd_in.code == CMD_WRITE && any_rd)) |=> !verdict_out.accepted)
        else $error("turnaround during burst");
    a_mrw_ends_idle: assert property ($rose(phase_out == DEV_MRW) |-> ##[1:MRW_LIM]
        (phase_out == DEV_RUN && all_idle_out)) else $error("register write did not end");
endmodule // legality_checker

bind cross_bank_legality legality_checker #(.NUM_BANK(NUM_BANK)) i_legality_checker (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .cke_in(cke_in),
    .cmd_valid_in(cmd_valid_in),
    .cmd_in(cmd_in),
    .verdict_out(verdict_out),
    .bank_state_out(bank_state_out),
    .phase_out(phase_out),
    .all_idle_out(all_idle_out)
);

// ===== test/testbench.sv
/* testbench: drives cross_bank_legality through the controller model.
   assumes the bound checker and a short init count. */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin n_fail++; \
    $display("wrong value %s expected %0h seen %0h", nm, e, g); end end
module testbench
    import bank_legal_pkg::*;
;
    localparam int INIT_TB = 10;
    logic clk_in = 1'b0;
    logic reset_in = 1'b1;
    logic cke_in = 1'b1;
    logic power_exit_in = 1'b0;
    logic issue = 1'b0;
    command_type req = '0;
    logic cmd_valid;
    command_type cmd_bus;
    verdict_type verdict_out;
    bank_state_type [NUM_BANKS-1:0] bank_state_out;
    dev_phase_type phase_out;
    logic all_idle_out;
    verdict_type expq[$];
    verdict_type exp_v;
    int n_fail = 0;
    int num_checks = 0;
    int cycles = 0;
    int seed = 39;
    int a;
    int blen;

    always #5 clk_in = ~clk_in;

    ctrl_model i_ctrl_model (.issue_in(issue), .req_in(req), .cmd_valid_out(cmd_valid),
        .cmd_out(cmd_bus));
    cross_bank_legality #(.INIT_CYCLES(INIT_TB)) i_cross_bank_legality (.clk_in(clk_in),
        .reset_in(reset_in), .cke_in(cke_in), .power_exit_in(power_exit_in),
        .cmd_valid_in(cmd_valid), .cmd_in(cmd_bus), .verdict_out(verdict_out),
        .bank_state_out(bank_state_out), .phase_out(phase_out), .all_idle_out(all_idle_out));

    // *****
    // tasks
    // *****
    task automatic stop_test();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask

    // e: 1 accept, 0 reject, -1 no verdict expected
    task automatic cmd(input cmd_code_type c, input int bk, input logic ap, input int e);
        @(posedge clk_in);
        #1;
        req.code = c;
        req.bank = bk[2:0];
        req.all_banks = (c == CMD_PRECHARGE);
        req.auto_pre = ap;
        req.burst_cycles = blen[7:0];
        issue = 1'b1;
        if (e >= 0) expq.push_back(verdict_type'(e ? 2'b10 : 2'b01));
        @(posedge clk_in);
        #1;
        issue = 1'b0;
    endtask

    // *****
    // verdict watcher and timeout
    // *****
    always @(posedge clk_in) begin
        #2;
        if (verdict_out !== 2'b00) begin
            if (expq.size() == 0) begin
                `CHK("unexpected verdict", 2'b00, verdict_out)
            end else begin
                exp_v = expq.pop_front();
                `CHK("verdict", exp_v, verdict_out)
            end
        end
    end

    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 2000) begin
            n_fail++;
            stop_test();
        end
    end

    // *****
    // main sequence
    // *****
    initial begin
        repeat (8) @(posedge clk_in);
        #1;
        reset_in = 1'b0;
        idle(4);
        `CHK("phase", DEV_POWER_ON, phase_out)
        blen = 8;
        a = $unsigned($random(seed)) % 6;
        cmd(CMD_READ, a, 0, 0);
        cmd(CMD_MRW_RESET, 0, 0, 1);
        `CHK("phase", DEV_RESETTING, phase_out)
        cmd(CMD_ACTIVATE, a, 0, 0);
        cmd(CMD_MRR, 0, 0, 1);
        `CHK("phase", DEV_RESET_MRR, phase_out)
        idle(INIT_TB + 20);
        `CHK("all idle", 1'b1, all_idle_out)
        cmd(CMD_ACTIVATE, a, 0, 1);
        `CHK("bank a", BANK_ACTIVATING, bank_state_out[a])
        cmd(CMD_ACTIVATE, a + 1, 0, 1);
        idle(RCD_CYC + 1);
        `CHK("bank b", BANK_ACTIVE, bank_state_out[a+1])
        cmd(CMD_READ, a, 0, 1);
        `CHK("bank a", BANK_READING, bank_state_out[a])
        cmd(CMD_WRITE, a + 1, 0, 0);
        cmd(CMD_BST, a + 1, 0, 0);
        cmd(CMD_BST, a, 0, 1);
        `CHK("bank a", BANK_ACTIVE, bank_state_out[a])
        blen = 4 + $unsigned($random(seed)) % 4;
        cmd(CMD_WRITE, a + 1, 0, 1);
        `CHK("bank b", BANK_WRITING, bank_state_out[a+1])
        cmd(CMD_READ, a, 0, 0);
        idle(8);
        `CHK("bank b", BANK_ACTIVE, bank_state_out[a+1])
        cmd(CMD_READ, a, 1, 1);
        `CHK("bank a", BANK_READING_AP, bank_state_out[a])
        cmd(CMD_ACTIVATE, a + 2, 0, 1);
        idle(16);
        `CHK("bank a", BANK_IDLE, bank_state_out[a])
        cmd(CMD_MRR, a + 1, 0, 1);
        `CHK("bank b", BANK_ACTIVE_MRR, bank_state_out[a+1])
        idle(MRR_CYC + 2);
        `CHK("bank b", BANK_ACTIVE, bank_state_out[a+1])
        cmd(CMD_MRW, 0, 0, 0);
        cmd(CMD_PRECHARGE, 0, 0, 1);
        idle(RP_CYC + 2);
        `CHK("all idle", 1'b1, all_idle_out)
        cmd(CMD_MRW, 0, 0, 1);
        `CHK("phase", DEV_MRW, phase_out)
        cmd(CMD_ACTIVATE, a, 0, 0);
        idle(MRW_CYC + 2);
        `CHK("all idle", 1'b1, all_idle_out)
        cmd(CMD_MRR, a, 0, 1);
        `CHK("bank a", BANK_IDLE_MRR, bank_state_out[a])
        idle(MRR_CYC + 2);
        `CHK("bank a", BANK_IDLE, bank_state_out[a])
        cke_in = 1'b0;
        idle(3);
        cmd(CMD_ACTIVATE, a, 0, -1);
        cke_in = 1'b1;
        idle(4);
        power_exit_in = 1'b1;
        idle(1);
        power_exit_in = 1'b0;
        cmd(CMD_ACTIVATE, a, 0, -1);
        idle(EXIT_CYC + 2);
        cmd(CMD_ACTIVATE, a, 0, 1);
        cmd(CMD_NOP, a + 1, 0, -1);
        idle(4);
        `CHK("bank a", BANK_ACTIVE, bank_state_out[a])
        `CHK("queue", 0, expq.size())
        stop_test();
    end
endmodule // testbench
